// ### logic/tpm_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpm_map.svh"
module tpm_top #(
  parameter int CNT_W = 48
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire tpm_pkg::tpm_evsel_t i_sel0,
  input wire tpm_pkg::tpm_evsel_t i_sel1,
  input wire logic [2:0] i_fix_en,
  input wire logic [2:0] i_fix_any,
  input wire tpm_pkg::tpm_ev_t i_ev_own,
  input wire tpm_pkg::tpm_ev_t i_ev_other,
  input wire tpm_pkg::tpm_offc_t i_offc,
  input wire logic [63:0] i_offcore_qualifier_0,
  input wire logic [63:0] i_offcore_qualifier_1,
  input wire logic [63:0] i_stat_clr,
  input wire logic i_sample_en,
  input wire logic [CNT_W-1:0] i_reload,
  input wire logic i_ret_valid,
  input wire tpm_pkg::tpm_arch_t i_ret_state,
  input wire logic [63:0] i_ds_base,
  input wire logic i_ds_ready,
  output logic [CNT_W-1:0] o_general_counter_0,
  output logic [CNT_W-1:0] o_general_counter_1,
  output logic [2:0][CNT_W-1:0] o_fixed_function_counters,
  output logic [63:0] o_global_counter_status,
  output logic [63:0] o_perf_capability_reg,
  output logic [7:0] o_arch_version,
  output logic o_ds_valid,
  output logic [63:0] o_ds_addr,
  output logic [63:0] o_ds_data,
  output logic o_rec_done
);
  tpm_pkg::tpm_state_t state_r;
  tpm_pkg::tpm_arch_t snap_r;
  logic [63:0] eip_r;
  logic [63:0] ldla_r;
  logic [63:0] dla_r;
  logic [7:0] off_r;
  logic last_r;
  logic [1:0] ovf;
  logic [2:0] fix_ovf;
  logic [2:0] fix_hit;
  logic sample_ok;
  logic start;
  logic load;
  logic done;
  logic is_gpr;
  logic [7:0] goff;
  logic [63:0] rec_word;
  logic [63:0] stat_set;

  // general counters; counter 0 frozen while its record is pending
  tpm_gen_ctr #(.CNT_W(CNT_W)) u_gc0 (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_sel(i_sel0), .i_ev_own(i_ev_own),
    .i_ev_other(i_ev_other), .i_offc(i_offc), .i_qual0(i_offcore_qualifier_0),
    .i_qual1(i_offcore_qualifier_1), .i_hold(state_r != tpm_pkg::S_IDLE),
    .i_ld(done), .i_ld_val(i_reload), .o_count(o_general_counter_0), .o_ovf(ovf[0])
  );
  tpm_gen_ctr #(.CNT_W(CNT_W)) u_gc1 (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_sel(i_sel1), .i_ev_own(i_ev_own),
    .i_ev_other(i_ev_other), .i_offc(i_offc), .i_qual0(i_offcore_qualifier_0),
    .i_qual1(i_offcore_qualifier_1), .i_hold(1'b0), .i_ld(1'b0), .i_ld_val('0),
    .o_count(o_general_counter_1), .o_ovf(ovf[1])
  );

  // fixed counters: retired instructions, core cycles, reference cycles
  assign fix_hit = {i_ev_own.ref_cyc | (i_fix_any[2] & i_ev_other.ref_cyc),
                    i_ev_own.core_cyc | (i_fix_any[1] & i_ev_other.core_cyc),
                    i_ev_own.instr_ret | (i_fix_any[0] & i_ev_other.instr_ret)};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_fix
      always_ff @(posedge i_clk)
      begin
        if (!i_nrst)
        begin
          o_fixed_function_counters[gi] <= '0;
          fix_ovf[gi] <= 1'b0;
        end
        else
        begin
          o_fixed_function_counters[gi] <= o_fixed_function_counters[gi]
                                           + {{(CNT_W-1){1'b0}}, i_fix_en[gi] & fix_hit[gi]};
          fix_ovf[gi] <= i_fix_en[gi] & fix_hit[gi] & (&o_fixed_function_counters[gi]);
        end
      end
    end
  endgenerate

  // sticky overflow status, a new overflow beats a same-cycle clear
  assign stat_set = {29'h0, fix_ovf, 30'h0, ovf};
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_global_counter_status <= 64'h0;
    else
      o_global_counter_status <= (o_global_counter_status & ~i_stat_clr) | stat_set;
  end

  // identity of the monitoring facility
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_arch_version <= 8'h00;
      o_perf_capability_reg <= 64'h0;
    end
    else
    begin
      o_arch_version <= `TPM_ARCH_VERSION;
      o_perf_capability_reg <= {52'h0, `TPM_CAP_FMT, 8'h00};
    end
  end

  // sampling trigger, counter 0 only, precise events only
  assign sample_ok = i_sample_en && tpm_pkg::tpm_is_precise(i_sel0);
  assign start = ovf[0] && sample_ok && state_r == tpm_pkg::S_IDLE;
  assign load = state_r == tpm_pkg::S_WRITE && !last_r && (!o_ds_valid || i_ds_ready);
  assign done = o_ds_valid && i_ds_ready && last_r;

  // record word for the current byte offset
  assign is_gpr = off_r >= `TPM_REC_GPR && off_r < `TPM_REC_STAT;
  assign goff = off_r - `TPM_REC_GPR;
  assign rec_word = (off_r == `TPM_REC_FLAGS) ? snap_r.saved_flags
                  : (off_r == `TPM_REC_IP) ? snap_r.saved_instr_pointer
                  : is_gpr ? snap_r.gpr[goff[6:3]]
                  : (off_r == `TPM_REC_STAT) ? o_global_counter_status
                  : (off_r == `TPM_REC_DLA) ? dla_r
                  : (off_r == `TPM_REC_EIP) ? eip_r
                  : 64'h0;

  // last retirement: pointer and address of the eventing instruction
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      eip_r <= 64'h0;
      ldla_r <= 64'h0;
    end
    else if (i_ret_valid && state_r == tpm_pkg::S_IDLE && !start)
    begin
      eip_r <= i_ret_state.saved_instr_pointer;
      ldla_r <= i_ret_state.dla;
    end
  end

  // sampling sequence: arm, capture next retirement, stream record
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_r <= tpm_pkg::S_IDLE;
      snap_r <= '0;
      dla_r <= 64'h0;
    end
    else
    begin
      case (state_r)
        tpm_pkg::S_IDLE:
          if (start)
          begin
            dla_r <= (i_sel0.code == `TPM_EV_MEM || i_sel0.code == `TPM_EV_RQ)
                     ? ldla_r : 64'h0;
            state_r <= tpm_pkg::S_ARMED;
          end
        tpm_pkg::S_ARMED:
          if (i_ret_valid)
          begin
            snap_r <= i_ret_state;
            state_r <= tpm_pkg::S_WRITE;
          end
        tpm_pkg::S_WRITE:
          if (done)
            state_r <= tpm_pkg::S_IDLE;
        default:
          state_r <= tpm_pkg::S_IDLE;
      endcase
    end
  end

  // debug store beats, one 64-bit field each
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst || state_r != tpm_pkg::S_WRITE)
    begin
      off_r <= `TPM_REC_FLAGS;
      last_r <= 1'b0;
      o_ds_valid <= 1'b0;
      o_ds_addr <= 64'h0;
      o_ds_data <= 64'h0;
    end
    else if (load)
    begin
      o_ds_valid <= 1'b1;
      o_ds_data <= rec_word;
      o_ds_addr <= i_ds_base + {56'h0, off_r};
      off_r <= off_r + `TPM_REC_STEP;
      last_r <= off_r == `TPM_REC_LAST;
    end
    else if (o_ds_valid && i_ds_ready)
      o_ds_valid <= 1'b0;
  end

  // one-cycle pulse once the last beat is taken
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_rec_done <= 1'b0;
    else
      o_rec_done <= done;
  end

  // beat counter used only by checks
  logic [5:0] beats_r;
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst || state_r != tpm_pkg::S_WRITE)
      beats_r <= 6'h00;
    else if (o_ds_valid && i_ds_ready)
      beats_r <= beats_r + 6'h01;
  end

  sequence s_beat;
    o_ds_valid && i_ds_ready;
  endsequence

  chk_id_values: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $past(i_nrst) |-> o_arch_version == 8'h03 && o_perf_capability_reg[11:8] == 4'h2)
    else $error("identity values wrong");
  chk_rec_beats: assert property (@(posedge i_clk) disable iff (!i_nrst)
    done |-> beats_r == 6'h17)
    else $error("record not 24 beats");
  chk_first_flags: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_ds_valid && o_ds_addr == i_ds_base |-> o_ds_data == snap_r.saved_flags)
    else $error("first field not flags");
  chk_addr_step: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s_beat ##1 o_ds_valid |-> o_ds_addr == $past(o_ds_addr) + 64'h8)
    else $error("address step not 8");
  chk_rsvd_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_ds_valid && (o_ds_addr - i_ds_base inside {64'hA0, 64'hA8, 64'hB8}) |-> o_ds_data == 64'h0)
    else $error("reserved slot not zero");
  chk_branch_nodla: assert property (@(posedge i_clk) disable iff (!i_nrst)
    start && (i_sel0.code == 8'hC4 || i_sel0.code == 8'hC5) |=> dla_r == 64'h0)
    else $error("branch sample has address");
  chk_gc0_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == tpm_pkg::S_IDLE ##1 state_r == tpm_pkg::S_ARMED |-> $past(ovf[0]))
    else $error("sample not from counter 0");
  chk_next_instr: assert property (@(posedge i_clk) disable iff (!i_nrst)
    state_r == tpm_pkg::S_ARMED ##1 state_r == tpm_pkg::S_WRITE
      |-> snap_r == $past(i_ret_state) && !$past(start))
    else $error("wrong instruction captured");
  chk_reload_after: assert property (@(posedge i_clk) disable iff (!i_nrst)
    done |=> o_general_counter_0 == $past(i_reload) && state_r == tpm_pkg::S_IDLE)
    else $error("reload not after record");
endmodule : tpm_top
`default_nettype wire

// ### logic/tpm_map.svh
`ifndef TPM_MAP_SVH
`define TPM_MAP_SVH
`define TPM_ARCH_VERSION 8'h03
`define TPM_CAP_FMT_LSB 8
`define TPM_CAP_FMT 4'h2
`define TPM_EV_CYC 8'h3C
`define TPM_UM_CORE 8'h00
`define TPM_UM_REF 8'h01
`define TPM_EV_INSTR 8'hC0
`define TPM_EV_BR 8'hC4
`define TPM_EV_MISP 8'hC5
`define TPM_EV_MEM 8'h04
`define TPM_EV_RQ 8'h03
`define TPM_EV_OFFC 8'hB7
`define TPM_UM_OFF0 8'h01
`define TPM_UM_OFF1 8'h02
`define TPM_OFF_LAT_BIT 38
`define TPM_STAT_FIX_LSB 32
`define TPM_REC_FLAGS 8'h00
`define TPM_REC_IP 8'h08
`define TPM_REC_GPR 8'h10
`define TPM_REC_STAT 8'h90
`define TPM_REC_DLA 8'h98
`define TPM_REC_EIP 8'hB0
`define TPM_REC_LAST 8'hB8
`define TPM_REC_STEP 8'h08
`define TPM_REC_BEATS 24
`endif

// ### logic/tpm_pkg.sv
`default_nettype none
package tpm_pkg;
  typedef struct packed {
    logic en;
    logic any_thread_qualifier;
    logic [7:0] sub_event_mask;
    logic [7:0] code;
  } tpm_evsel_t;
  typedef struct packed {
    logic instr_ret;
    logic core_cyc;
    logic ref_cyc;
    logic branch_retired_event;
    logic mispredict_retired_event;
    logic [2:0] memory_uop_retired_event;
    logic [1:0] recycle_queue_event;
  } tpm_ev_t;
  typedef struct packed {
    logic req;
    logic [15:0] req_type;
    logic [7:0] outst;
  } tpm_offc_t;
  typedef struct packed {
    logic [63:0] saved_flags;
    logic [63:0] saved_instr_pointer;
    logic [15:0][63:0] gpr;
    logic [63:0] dla;
  } tpm_arch_t;
  typedef enum {S_IDLE, S_ARMED, S_WRITE} tpm_state_t;

  // precise-capable select and mask pairs
  function automatic logic tpm_is_precise(input tpm_evsel_t s);
    logic [7:0] m;
    m = s.sub_event_mask;
    case (s.code)
      8'hC4: tpm_is_precise = m inside {8'h00, 8'h7E, 8'hFE, 8'hF9, 8'hFD, 8'hFB, 8'hEB,
                                        8'hBF, 8'hF7};
      8'hC5: tpm_is_precise = m inside {8'h00, 8'h7E, 8'hFE, 8'hFB, 8'hEB, 8'hF7};
      8'h04: tpm_is_precise = m inside {8'h02, 8'h04, 8'h08};
      8'h03: tpm_is_precise = m inside {8'h01, 8'h08};
      default: tpm_is_precise = 1'b0;
    endcase
  endfunction : tpm_is_precise
endpackage : tpm_pkg
`default_nettype wire

// ### logic/tpm_gen_ctr.sv
`timescale 1ns/10ps
`default_nettype none
`include "tpm_map.svh"
module tpm_gen_ctr #(
  parameter int CNT_W = 48
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire tpm_pkg::tpm_evsel_t i_sel,
  input wire tpm_pkg::tpm_ev_t i_ev_own,
  input wire tpm_pkg::tpm_ev_t i_ev_other,
  input wire tpm_pkg::tpm_offc_t i_offc,
  input wire logic [63:0] i_qual0,
  input wire logic [63:0] i_qual1,
  input wire logic i_hold,
  input wire logic i_ld,
  input wire logic [CNT_W-1:0] i_ld_val,
  output logic [CNT_W-1:0] o_count,
  output logic o_ovf
);
  logic [7:0] m;
  logic is_cyc;
  logic cyc_any;
  logic hit;
  logic [63:0] q;
  logic off_hit;
  logic [7:0] inc;
  logic [CNT_W:0] sum;

  // event decode from the select fields
  assign m = i_sel.sub_event_mask;
  assign is_cyc = i_sel.code == `TPM_EV_CYC;
  assign cyc_any = i_sel.any_thread_qualifier;
  assign q = (m == `TPM_UM_OFF0) ? i_qual0 : (m == `TPM_UM_OFF1) ? i_qual1 : 64'h0;
  assign off_hit = i_offc.req & (|(i_offc.req_type & q[15:0]));
  assign hit = (is_cyc && m == `TPM_UM_CORE) ? (i_ev_own.core_cyc | (cyc_any & i_ev_other.core_cyc))
             : (is_cyc && m == `TPM_UM_REF) ? (i_ev_own.ref_cyc | (cyc_any & i_ev_other.ref_cyc))
             : (i_sel.code == `TPM_EV_INSTR) ? i_ev_own.instr_ret
             : (i_sel.code == `TPM_EV_BR) ? i_ev_own.branch_retired_event
             : (i_sel.code == `TPM_EV_MISP) ? i_ev_own.mispredict_retired_event
             : (i_sel.code == `TPM_EV_MEM) ? |(m[3:1] & i_ev_own.memory_uop_retired_event)
             : (i_sel.code == `TPM_EV_RQ) ? ((m[0] & i_ev_own.recycle_queue_event[0])
                                            | (m[3] & i_ev_own.recycle_queue_event[1]))
             : (i_sel.code == `TPM_EV_OFFC) ? off_hit
             : 1'b0;
  // latency mode adds weighted outstanding requests each cycle
  assign inc = !i_sel.en ? 8'h00
             : (i_sel.code == `TPM_EV_OFFC && q[`TPM_OFF_LAT_BIT]) ? i_offc.outst
             : {7'h00, hit};
  assign sum = {1'b0, o_count} + {{(CNT_W-7){1'b0}}, inc};

  // counter with carry-out overflow pulse
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_count <= '0;
      o_ovf <= 1'b0;
    end
    else
    begin
      o_ovf <= !i_hold && !i_ld && sum[CNT_W];
      if (i_ld)
        o_count <= i_ld_val;
      else if (!i_hold)
        o_count <= sum[CNT_W-1:0];
    end
  end

  // refuse widths that the carry and increment logic cannot serve
  if (CNT_W < 9 || CNT_W > 64)
  begin : g_bad_width
    $error("counter width out of range");
  end
endmodule : tpm_gen_ctr
`default_nettype wire

// ### test/tpm_ds_model.sv
`timescale 1ns/10ps
`default_nettype none
module tpm_ds_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [63:0] i_addr,
  input wire logic [63:0] i_data,
  input wire logic [63:0] i_base,
  output logic o_ready
);
  logic tog_r = 1'b0;
  logic [63:0] mem [0:23];
  int beats = 0;
  // slow mode refuses every other cycle
  always_ff @(posedge i_clk)
  begin
    tog_r <= ~tog_r;
  end
  assign o_ready = i_slow ? tog_r : 1'b1;
  // accepted beats land by byte offset
  always @(posedge i_clk)
  begin
    if (i_valid && o_ready)
    begin
      mem[5'((i_addr - i_base) >> 3)] = i_data;
      beats = beats + 1;
    end
  end
endmodule : tpm_ds_model
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH %0t %s", $time, m); end end
module tb_top;
  localparam int CNT_W = 9;
  localparam logic [9:0] EV_INS = 10'h200, EV_CYC = 10'h100, EV_BR = 10'h040;
  localparam logic [9:0] EV_MP = 10'h020, EV_M0 = 10'h004, EV_RQ1 = 10'h002;
  int fail_count = 0, n_tests = 0;
  logic i_clk = 1'b0, i_nrst = 1'b0, smp_en = 1'b0, ret_v = 1'b0, slow = 1'b0;
  tpm_pkg::tpm_evsel_t sel0 = '0, sel1 = '0;
  logic [2:0] fix_en = 3'h0, fix_any = 3'h0;
  tpm_pkg::tpm_ev_t ev_own = '0, ev_oth = '0;
  tpm_pkg::tpm_offc_t offc = '0;
  logic [63:0] qual0 = '0, qual1 = '0, stat_clr = '0, base = 64'h1000;
  logic [CNT_W-1:0] reload = 9'h1FE, gc0, gc1;
  tpm_pkg::tpm_arch_t ret_st = '0;
  logic [2:0][CNT_W-1:0] fix;
  logic [63:0] stat, caps, ds_addr, ds_data;
  logic [7:0] ver;
  logic ds_valid, ds_ready, rec_done;
  tpm_top #(.CNT_W(CNT_W)) i_tpm_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_sel0(sel0),
    .i_sel1(sel1), .i_fix_en(fix_en), .i_fix_any(fix_any), .i_ev_own(ev_own),
    .i_ev_other(ev_oth), .i_offc(offc), .i_offcore_qualifier_0(qual0),
    .i_offcore_qualifier_1(qual1), .i_stat_clr(stat_clr), .i_sample_en(smp_en),
    .i_reload(reload), .i_ret_valid(ret_v), .i_ret_state(ret_st), .i_ds_base(base),
    .i_ds_ready(ds_ready), .o_general_counter_0(gc0), .o_general_counter_1(gc1),
    .o_fixed_function_counters(fix), .o_global_counter_status(stat),
    .o_perf_capability_reg(caps), .o_arch_version(ver), .o_ds_valid(ds_valid),
    .o_ds_addr(ds_addr), .o_ds_data(ds_data), .o_rec_done(rec_done));
  tpm_ds_model i_tpm_ds_model (.i_clk(i_clk), .i_slow(slow), .i_valid(ds_valid),
    .i_addr(ds_addr), .i_data(ds_data), .i_base(base), .o_ready(ds_ready));
  // clock
  always #20 i_clk = ~i_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  function automatic tpm_pkg::tpm_evsel_t sel(input logic [7:0] c, m, input logic a);
    sel = '{1'b1, a, m, c};
  endfunction : sel
  // one event pulse on each thread
  task automatic pulse(input logic [9:0] own, oth);
    ev_own = own;
    ev_oth = oth;
    tick(1);
    ev_own = '0;
    ev_oth = '0;
    tick(2);
  endtask : pulse
  function automatic tpm_pkg::tpm_arch_t st(input logic [7:0] t);
    st.saved_flags = {t, 56'hF1};
    st.saved_instr_pointer = {t, 56'hA1};
    st.dla = {t, 56'hDA};
    for (int i = 0; i < 16; i++)
      st.gpr[i] = {t, 48'h0, 8'(i)};
  endfunction : st
  // expected beat k of a record
  function automatic logic [63:0] want(input int k, input tpm_pkg::tpm_arch_t a, b,
    input logic d);
    if (k == 0) return b.saved_flags;
    if (k == 1) return b.saved_instr_pointer;
    if (k < 18) return b.gpr[k-2];
    if (k == 18) return 64'h1;
    if (k == 19) return d ? a.dla : 64'h0;
    if (k == 22) return a.saved_instr_pointer;
    return 64'h0;
  endfunction : want
  task automatic s_reset;
    tick(6);
    `CHK(ver, 8'h00, "version in reset")
    i_nrst = 1'b1;
    tick(1);
    `CHK(ver, 8'h03, "version")
    `CHK(caps, 64'h200, "caps")
  endtask : s_reset
  task automatic s_count;
    logic [CNT_W-1:0] b0, b1;
    sel0 = sel(8'h04, 8'h04, 1'b0);
    sel1 = sel(8'hC4, 8'h00, 1'b0);
    pulse(EV_BR | 10'h008, 10'h0);
    pulse(EV_M0, EV_BR);
    `CHK(gc0, 9'h001, "gc0 select")
    `CHK(gc1, 9'h001, "gc1 select")
    sel1 = sel(8'h3C, 8'h00, 1'b1);
    b1 = gc1;
    pulse(10'h0, EV_CYC);
    `CHK(gc1, b1 + 9'h001, "any core cycles")
    sel1 = sel(8'hC0, 8'h00, 1'b1);
    pulse(10'h0, EV_INS);
    `CHK(gc1, b1 + 9'h001, "any instr on gc")
    fix_en = 3'h7;
    fix_any = 3'h1;
    // own reference cycle plus sibling events on all three fixed counters
    pulse(10'h080, EV_INS | EV_CYC | 10'h080);
    `CHK(fix[0], 9'h001, "fixed any")
    `CHK(fix[1], 9'h000, "fixed own only")
    `CHK(fix[2], 9'h001, "fixed ref own only")
    fix_en = 3'h0;
    qual0 = 64'h1;
    qual1 = 64'h40_0000_0001;
    sel0 = sel(8'hB7, 8'h01, 1'b0);
    sel1 = sel(8'hB7, 8'h02, 1'b0);
    b0 = gc0;
    b1 = gc1;
    offc = '{1'b1, 16'h0001, 8'h05};
    tick(2);
    offc = '0;
    tick(2);
    `CHK(gc0, b0 + 9'h002, "occurrences")
    `CHK(gc1, b1 + 9'h00A, "weighted cycles")
    sel1 = '0;
  endtask : s_count
  task automatic s_gc1_only;
    int n;
    sel0 = '0;
    sel1 = sel(8'hC4, 8'h00, 1'b0);
    smp_en = 1'b1;
    n = i_tpm_ds_model.beats;
    ev_own = EV_BR;
    tick(512);
    ev_own = '0;
    tick(40);
    `CHK(stat[1], 1'b1, "gc1 overflow")
    `CHK(i_tpm_ds_model.beats, n, "gc1 sampled")
    sel1 = '0;
  endtask : s_gc1_only
  // overflow gc0 on a precise event and judge the record
  task automatic s_sample(input logic [7:0] c, m, input logic [9:0] ev, input logic d);
    int n, nb, k;
    tpm_pkg::tpm_arch_t a, b;
    a = st(c ^ 8'h5A);
    b = st(c);
    stat_clr = '1;
    sel0 = sel(c, m, 1'b0);
    smp_en = 1'b1;
    tick(1);
    stat_clr = '0;
    nb = i_tpm_ds_model.beats;
    n = 512 - int'(gc0);
    ev_own = ev;
    if (n > 1) tick(n - 1);
    ret_v = 1'b1;
    ret_st = a;
    tick(1);
    ev_own = '0;
    ret_v = 1'b0;
    tick(4);
    ret_v = 1'b1;
    ret_st = b;
    tick(1);
    ret_v = 1'b0;
    for (k = 0; k < 200 && rec_done !== 1'b1; k++) tick(1);
    `CHK(rec_done, 1'b1, "record done")
    `CHK(gc0, reload, "reload")
    `CHK(i_tpm_ds_model.beats - nb, 24, "beat count")
    for (k = 0; k < 24; k++)
      `CHK(i_tpm_ds_model.mem[k], want(k, a, b, d), "record beat")
    tick(3);
  endtask : s_sample
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  // watchdog
  initial
  begin
    #400000;
    fail_count++;
    $display("MISMATCH %0t %s", $time, "watchdog expired");
    complete_run;
  end
  initial
  begin
    s_reset;
    s_count;
    s_gc1_only;
    slow = 1'b1;
    s_sample(8'h04, 8'h02, EV_M0, 1'b1);
    slow = 1'b0;
    s_sample(8'hC4, 8'hF7, EV_BR, 1'b0);
    s_sample(8'hC5, 8'h00, EV_MP, 1'b0);
    s_sample(8'h03, 8'h08, EV_RQ1, 1'b1);
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
